// File: inc/flash_protect_cfg.svh
/*
 Offsets, field positions, reset values and sizes for the flash partition and protection
 configuration block. Assumes it is included by bare name from the design.
*/
`ifndef FLASH_PROTECT_CFG_SVH
`define FLASH_PROTECT_CFG_SVH
`define REG_REVISION 16'h8005
`define REG_PART_ID 16'h8006
`define REG_PARTITION 16'h800a
`define REG_CODE_PROT 16'h800b
`define REG_CTRL 16'h8010
`define REG_STATUS 16'h8011
`define BIT_LVP 13
`define BIT_SAF_WP 11
`define BIT_EE_WP 10
`define BIT_CFG_WP 9
`define BIT_BOOT_WP 8
`define BIT_APP_WP 7
`define BIT_SAF_EN_N 4
`define BIT_BOOT_EN_N 3
`define BIT_CP_N 0
`define PART_IMPL_MASK 14'h2f9f
`define CODE_IMPL_MASK 14'h0001
`define CFG_ERASED 14'h3fff
`define PROG_WORDS 15'h2000
`define SAF_WORDS 15'h0080
`define BOOT_512 15'h0200
`define BOOT_1K 15'h0400
`define BOOT_2K 15'h0800
`define BOOT_4K 15'h1000
`define SIZE_512 3'h7
`define SIZE_1K 3'h6
`define SIZE_2K 3'h5
`define REV_FIXED 2'h2
`define ID_FIXED 2'h3
`define CTRL_BULK 0
`define CTRL_WERR_CLR 1
`define CTRL_LVP_ACT 2
`endif

// File: inc/flash_protect_pkg.sv
/*
 Types for the flash partition and protection configuration block.
 Assumes the configuration header sits on the include path.
*/
package flash_protect_pkg;
	typedef enum logic [1:0] {
		REGION_APP,
		REGION_BOOT,
		REGION_SAF,
		REGION_CONFIG
	} region_e;
	typedef struct packed {
		logic wr_i_dummy;
	} unused_s;
	typedef struct packed {
		logic [15:0] addr;
		logic [13:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	typedef struct packed {
		logic valid;
		region_e region;
		logic [14:0] addr;
	} nvm_write_s;
	typedef struct packed {
		logic [13:0] part_cfg;
		logic [13:0] code_cfg;
		logic [13:0] rdata;
		logic write_error;
		logic wr_allow;
		logic lvp_q1;
		logic lvp_q2;
		logic lvp_q3;
		logic lvp_active;
	} state_s;
endpackage

// File: hw/flash_partition_protect_config.sv
/*
 Holds the user flash partition, write-protection, code-protection and programming-mode
 settings plus read-only revision and part identifier words, and judges each flash write.
 Assumes one 100 MHz clock, a synchronous active-high reset, and a bus master that keeps
 strobes one cycle long and never both at once.
*/
`timescale 1ns/1ps
`include "flash_protect_cfg.svh"
module flash_partition_protect_config #(
	parameter logic [5:0] MAJOR_REV = 6'h01, // Value is arbitrary.
	parameter logic [5:0] MINOR_REV = 6'h02, // Value is arbitrary.
	parameter logic [11:0] PART_ID = 12'h0a5c, // Value is arbitrary.
	parameter logic [14:0] PROG_SIZE = `PROG_WORDS
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire flash_protect_pkg::bus_req_s bus_i,
	output logic [13:0] rdata_o,
	input wire logic lvp_entry_i,
	input wire logic reset_pin_i,
	input wire logic reset_pin_enable_i,
	input wire flash_protect_pkg::nvm_write_s nvm_wr_i,
	input wire logic [14:0] fetch_addr_i,
	output logic wr_allow_o,
	output logic write_error_flag_o,
	output logic device_reset_o,
	output logic code_protect_o,
	output logic [14:0] boot_words_o,
	output logic [14:0] saf_base_o,
	output logic fetch_legal_o
);
	import flash_protect_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	state_s st_q;
	state_s st_d;
	logic boot_en;
	logic saf_en;
	logic [14:0] boot_words;
	logic [14:0] saf_base;
	logic region_wp;
	logic in_boot;
	logic in_saf;
	logic [13:0] wmask;
	logic [13:0] merged;
	logic bulk;

	// ---------------------------------------------------------------
	// Partition decode
	// ---------------------------------------------------------------
	always_comb begin
		boot_en = ~st_q.part_cfg[`BIT_BOOT_EN_N];
		saf_en = ~st_q.part_cfg[`BIT_SAF_EN_N];
		boot_words = 15'h0000;
		if (boot_en) begin
			case (st_q.part_cfg[2:0])
				`SIZE_512: boot_words = `BOOT_512;
				`SIZE_1K: boot_words = `BOOT_1K;
				`SIZE_2K: boot_words = `BOOT_2K;
				default: boot_words = `BOOT_4K;
			endcase
			if (boot_words > (PROG_SIZE >> 1)) begin
				boot_words = PROG_SIZE >> 1;
			end
		end
		saf_base = saf_en ? PROG_SIZE - `SAF_WORDS : PROG_SIZE;
		in_boot = nvm_wr_i.addr < boot_words;
		in_saf = saf_en && (nvm_wr_i.addr >= saf_base);
		// Region judged from the address for flash; the controller tags EEPROM and config.
		case (nvm_wr_i.region)
			REGION_CONFIG: region_wp = ~st_q.part_cfg[`BIT_CFG_WP];
			REGION_SAF: region_wp = ~st_q.part_cfg[`BIT_EE_WP];
			default: begin
				if (in_saf) begin
					region_wp = ~st_q.part_cfg[`BIT_SAF_WP];
				end else if (in_boot) begin
					region_wp = ~st_q.part_cfg[`BIT_BOOT_WP];
				end else begin
					region_wp = ~st_q.part_cfg[`BIT_APP_WP];
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		bulk = bus_i.wr && (bus_i.addr == `REG_CTRL) && bus_i.wdata[`CTRL_BULK];
		// The entry pin is asynchronous; a change counts once stages two and three agree.
		st_d.lvp_q1 = lvp_entry_i;
		st_d.lvp_q2 = st_q.lvp_q1;
		st_d.lvp_q3 = st_q.lvp_q2;
		if (st_q.lvp_q2 == st_q.lvp_q3) begin
			st_d.lvp_active = st_q.lvp_q3;
		end
		// Writes other than a bulk erase may only move bits toward protection; a one written never clears a zero.
		wmask = `PART_IMPL_MASK;
		if (!st_q.part_cfg[`BIT_BOOT_EN_N]) begin
			wmask[2:0] = 3'h0;
		end
		if (st_q.lvp_active) begin
			wmask[`BIT_LVP] = 1'b0;
		end
		merged = st_q.part_cfg & (bus_i.wdata | ~wmask);
		st_d.wr_allow = 1'b0;
		if (bulk) begin
			st_d.part_cfg = `CFG_ERASED;
			st_d.code_cfg = `CFG_ERASED;
		end else if (bus_i.wr && st_q.part_cfg[`BIT_CFG_WP]) begin
			if (bus_i.addr == `REG_PARTITION) begin
				st_d.part_cfg = merged;
			end
			if (bus_i.addr == `REG_CODE_PROT) begin
				st_d.code_cfg = st_q.code_cfg & (bus_i.wdata | ~`CODE_IMPL_MASK);
			end
		end
		if (bus_i.wr && (bus_i.addr == `REG_CTRL) && bus_i.wdata[`CTRL_WERR_CLR]) begin
			st_d.write_error = 1'b0;
		end
		if (nvm_wr_i.valid) begin
			st_d.wr_allow = ~region_wp;
			if (region_wp) begin
				st_d.write_error = 1'b1;
			end
		end
		// Register reads: answered in the following cycle, unmapped reads return zero.
		st_d.rdata = 14'h0000;
		if (bus_i.rd) begin
			case (bus_i.addr)
				`REG_REVISION: st_d.rdata = {`REV_FIXED, MAJOR_REV, MINOR_REV};
				`REG_PART_ID: st_d.rdata = {`ID_FIXED, PART_ID};
				`REG_PARTITION: st_d.rdata = st_q.part_cfg | ~`PART_IMPL_MASK;
				`REG_CODE_PROT: st_d.rdata = st_q.code_cfg | ~`CODE_IMPL_MASK;
				`REG_STATUS: st_d.rdata = {12'h000, st_q.lvp_active, st_q.write_error};
				default: st_d.rdata = 14'h0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_q <= '0;
			st_q.part_cfg <= `CFG_ERASED;
			st_q.code_cfg <= `CFG_ERASED;
		end else begin
			st_q <= st_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign rdata_o = st_q.rdata;
	assign wr_allow_o = st_q.wr_allow;
	assign write_error_flag_o = st_q.write_error;
	// With low-voltage entry enabled the pin always resets; otherwise its enable decides.
	// The far end must then use high voltage to enter programming.
	assign device_reset_o = st_q.part_cfg[`BIT_LVP] ? reset_pin_i
		: (reset_pin_enable_i & reset_pin_i);
	assign code_protect_o = ~st_q.code_cfg[`BIT_CP_N];
	assign boot_words_o = boot_words;
	assign saf_base_o = saf_base;
	assign fetch_legal_o = fetch_addr_i < saf_base;
endmodule // flash_partition_protect_config

// File: tb/flash_protect_props.sv
/* Port checker for the flash protection block.
 Assumes it is bound to that block and sees only its ports. */
`timescale 1ns/1ps
module flash_protect_props (
	input wire logic mclk_i, srst_i, lvp_entry_i, reset_pin_i, reset_pin_enable_i,
	input wire flash_protect_pkg::bus_req_s bus_i,
	input wire flash_protect_pkg::nvm_write_s nvm_wr_i,
	input wire logic [14:0] fetch_addr_i, boot_words_o, saf_base_o,
	input wire logic [13:0] rdata_o,
	input wire logic wr_allow_o, write_error_flag_o, device_reset_o,
	input wire logic code_protect_o, fetch_legal_o
);
	import flash_protect_pkg::*;
	logic ctl_q = 1'b0;
	// A control write is the only thing allowed to undo sticky state.
	always_ff @(posedge mclk_i) ctl_q <= bus_i.wr && bus_i.addr == 16'h8010;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	a_rev_fixed_bits: assert property (
		$past(bus_i.rd) && $past(bus_i.addr) == 16'h8005 |-> rdata_o[13:12] == 2'b10)
		else $error("revision fixed bits wrong");
	a_reset_pin_use: assert property (
		reset_pin_i && reset_pin_enable_i |-> device_reset_o) else $error("reset pin lost");
	a_fetch_vs_base: assert property (fetch_legal_o == (fetch_addr_i < saf_base_o)
		&& saf_base_o inside {15'h1f80, 15'h2000}) else $error("storage region fetch");
	a_boot_size_set: assert property (
		boot_words_o inside {15'h0000, 15'h0200, 15'h0400, 15'h0800, 15'h1000})
		else $error("boot size illegal");
	a_boot_size_held: assert property (
		$past(boot_words_o) != 15'h0000 && !ctl_q |-> boot_words_o == $past(boot_words_o))
		else $error("boot size changed");
	a_refused_sets_err: assert property (
		$past(nvm_wr_i.valid) && !wr_allow_o |-> write_error_flag_o) else $error("no error");
	a_err_held: assert property (
		$fell(write_error_flag_o) |-> ctl_q) else $error("error flag dropped");
	a_cp_held: assert property ($fell(code_protect_o) |-> ctl_q)
		else $error("code protection dropped");
endmodule // flash_protect_props
bind flash_partition_protect_config flash_protect_props u_flash_protect_props (.*);

// File: tb/flash_writer_model.sv
/* Flash write controller side: turns a bench request into one write attempt.
 Assumes requests come at most one per two clocks. */
`timescale 1ns/1ps
module flash_writer_model (
	input wire logic mclk_i,
	input wire logic go_i,
	input wire flash_protect_pkg::region_e region_i,
	input wire logic [14:0] addr_i,
	output flash_protect_pkg::nvm_write_s nvm_wr_o
);
	import flash_protect_pkg::*;
	initial nvm_wr_o = '0;
	// Idle address flips each cycle so a stale value never looks like a request.
	always @(posedge mclk_i) nvm_wr_o <= '{go_i, region_i, go_i ? addr_i : ~nvm_wr_o.addr};
endmodule // flash_writer_model

// File: tb/flash_partition_protect_config_bench.sv
/* Self-checking bench for the flash protection block.
 Assumes package, header, checker and writer model are compiled first. */
`timescale 1ns/1ps
module flash_partition_protect_config_bench;
	import flash_protect_pkg::*;
	logic mclk_i = 0, srst_i = 1, low_volt_prog_enable = 0, rpin = 0, rpen = 0, go = 0;
	bus_req_s bus = '0;
	region_e rg = REGION_APP;
	logic [14:0] ad = '0, fa = 15'h1f80, bw, sb;
	logic [13:0] rdata;
	nvm_write_s nw;
	logic ok, err, drst, cp, legal;
	int error_cnt = 0, n_checks = 0;
	always #5 mclk_i = ~mclk_i;
	flash_writer_model u_flash_writer_model (.mclk_i(mclk_i), .go_i(go), .region_i(rg),
		.addr_i(ad), .nvm_wr_o(nw));
	flash_partition_protect_config u_flash_partition_protect_config (.mclk_i(mclk_i),
		.srst_i(srst_i), .bus_i(bus), .rdata_o(rdata), .lvp_entry_i(low_volt_prog_enable), .reset_pin_i(rpin),
		.reset_pin_enable_i(rpen), .nvm_wr_i(nw), .fetch_addr_i(fa), .wr_allow_o(ok),
		.write_error_flag_o(err), .device_reset_o(drst), .code_protect_o(cp),
		.boot_words_o(bw), .saf_base_o(sb), .fetch_legal_o(legal));
	task chk(input string n, input logic [14:0] s, e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [15:0] a, input logic [13:0] d);
		@(posedge mclk_i) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk_i) bus.wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [15:0] a, input logic [13:0] e);
		@(posedge mclk_i) bus <= '{a, 14'h0000, 1'b0, 1'b1};
		@(posedge mclk_i) bus.rd <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	task att(input region_e r, input logic [14:0] a, input logic e);
		@(posedge mclk_i) go <= 1'b1;
		rg <= r;
		ad <= a;
		@(posedge mclk_i) go <= 1'b0;
		@(posedge mclk_i) #1 chk("allow", ok, e);
		chk("error", err, !e);
	endtask
	task s_size;
		logic [2:0] sz [4] = '{3'h7, 3'h6, 3'h5, 3'h0};
		logic [14:0] wd [4] = '{15'h0200, 15'h0400, 15'h0800, 15'h1000};
		wr(16'h800a, 14'h3ff8);
		chk("boot", bw, 15'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(16'h8010, 14'h0001);
			wr(16'h800a, 14'h3ff0 | sz[i]);
			chk("boot", bw, wd[i]);
			wr(16'h800a, 14'h3ff6);
			chk("boot", bw, wd[i]);
		end
	endtask
	task s_protect;
		int bt [5] = '{7, 8, 11, 10, 9};
		logic [13:0] en [5] = '{14'h0000, 14'h0008, 14'h0010, 14'h0000, 14'h0000};
		region_e rt [5] = '{REGION_APP, REGION_BOOT, REGION_APP, REGION_SAF, REGION_CONFIG};
		logic [14:0] at [5] = '{15'h0100, 15'h0010, 15'h1fff, 15'h0000, 15'h0000};
		for (int i = 0; i < 5; i++) begin
			wr(16'h8010, 14'h0001);
			wr(16'h800a, 14'h3fff ^ en[i]);
			att(rt[i], at[i], 1'b1);
			chk("fetch", legal, i != 2);
			wr(16'h800a, 14'h3fff ^ en[i] ^ (14'h0001 << bt[i]));
			att(rt[i], at[i], 1'b0);
			wr(16'h800a, 14'h3fff);
			rd(16'h800a, 14'h3fff ^ en[i] ^ (14'h0001 << bt[i]));
			wr(16'h8010, 14'h0002);
			chk("error", err, 1'b0);
		end
	endtask
	task s_cp_lvp;
		// The protection scenario leaves the configuration words locked; erase first.
		wr(16'h8010, 14'h0001);
		wr(16'h800b, 14'h0000);
		rd(16'h800b, 14'h3ffe);
		wr(16'h800b, 14'h3fff);
		chk("cp", cp, 1'b1);
		wr(16'h8010, 14'h0001);
		chk("cp", cp, 1'b0);
		@(posedge mclk_i) low_volt_prog_enable <= 1'b1;
		rpin <= 1'b1;
		repeat (5) @(posedge mclk_i);
		wr(16'h800a, 14'h1fff);
		rd(16'h800a, 14'h3fff);
		chk("reset", drst, 1'b1);
		@(posedge mclk_i) low_volt_prog_enable <= 1'b0;
		repeat (5) @(posedge mclk_i);
		wr(16'h800a, 14'h1fff);
		chk("reset", drst, 1'b0);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		srst_i <= 1'b0;
		rd(16'h8005, {2'b10, 6'h01, 6'h02});
		rd(16'h8006, {2'b11, 12'ha5c});
		rd(16'h8000, 14'h0000);
		s_size;
		s_protect;
		s_cp_lvp;
		report_and_stop;
	end
	initial begin
		#200000;
		error_cnt++;
		report_and_stop;
	end
endmodule // flash_partition_protect_config_bench
